// File: logic/tptu_defines.vh
// Notes on behaviour
// R01: half-period value counts clocks per half
// R02: half-period register is sixteen bits wide
// R03: software never writes half-period zero or one
// R04: one ten-bit dead-time register for all
// R05: dead time is value times two clocks
// R06: complementary turns on after dead time
// R07: zero dead-time value inserts no gap
// R08: control bit two selects double update
// R09: period-start sync loads all timing values
// R10: sync also latches the output-enable register
// R11: double mode adds midpoint sync and load
// R12: status bit zero marks second half
// R13: duty registers give high-side half-period on time
// R14: timing outputs are active high
// R15: single mode repeats values both halves
// R16: dead time shifts both edges away
// R17: each channel gives complementary center pair
// R18: interrupt request pulses on every sync
// R19: each edge moves by dead-time value
// R20: idle until period and duties written
// R21: counter steps each clock, syncs at boundaries
`ifndef TPTU_DEFINES_VH
`define TPTU_DEFINES_VH
// register indices on the plain register port
`define TPTU_ADDR_W 3
`define TPTU_IDX_HALF 3'h0
`define TPTU_IDX_DEAD 3'h1
`define TPTU_IDX_DUTY_A 3'h2
`define TPTU_IDX_DUTY_B 3'h3
`define TPTU_IDX_DUTY_C 3'h4
`define TPTU_IDX_CTRL 3'h5
`define TPTU_IDX_STATUS 3'h6
`define TPTU_IDX_OUTEN 3'h7
// widths
`define TPTU_DATA_W 16
`define TPTU_DEAD_W 10
`define TPTU_OUTEN_W 9
`define TPTU_CMP_W 18
// field positions
`define TPTU_CTRL_DOUBLE_BIT 2
`define TPTU_STAT_HALF_BIT 0
// reset values
`define TPTU_RST_16 16'h0000
`define TPTU_RST_DEAD 10'h000
`define TPTU_RST_OUTEN 9'h000
`define TPTU_ONE_16 16'h0001
`endif

// File: logic/tptu_timing.v
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tptu_defines.vh"

// one complementary, center-based output pair
module tptu_channel (
	input wire mclk,
	input wire reset,
	input wire running,
	input wire [`TPTU_DATA_W-1:0] edgeDist,
	input wire [`TPTU_DATA_W-1:0] halfCount,
	input wire [`TPTU_DATA_W-1:0] dutyCount,
	input wire [`TPTU_DEAD_W-1:0] deadCount,
	output reg highSide,
	output reg lowSide
);
	wire [`TPTU_CMP_W-1:0] posPlusDuty;
	wire [`TPTU_CMP_W-1:0] halfPlusDead;
	wire [`TPTU_CMP_W-1:0] lowLimit;
	wire highOn;
	wire lowOn;

	// compare terms widened so no sum overflows
	// R13: duty sets high on time
	assign posPlusDuty = {2'b00, edgeDist} + {2'b00, dutyCount};
	// R05 R19: dead value per edge
	assign halfPlusDead = {2'b00, halfCount} + {8'h00, deadCount};
	assign lowLimit = posPlusDuty + {8'h00, deadCount};
	// R16: both edges shifted by dead value
	assign highOn = (posPlusDuty >= halfPlusDead);
	// R06 R07: low waits dead time, zero gives none
	assign lowOn = (lowLimit < {2'b00, halfCount});

	// registered drive, both off while idle
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			highSide <= 1'b0;
			lowSide <= 1'b0;
		end else begin
			// R14: high level turns switch on
			highSide <= running & highOn;
			lowSide <= running & lowOn;
		end
	end
endmodule // tptu_channel

module tptu_timing (
	input wire mclk,
	input wire reset,
	input wire [`TPTU_ADDR_W-1:0] regAddr,
	input wire [`TPTU_DATA_W-1:0] regWriteData,
	input wire regWrite,
	input wire regRead,
	output reg [`TPTU_DATA_W-1:0] regReadData,
	output wire phaseAHigh,
	output wire phaseALow,
	output wire phaseBHigh,
	output wire phaseBLow,
	output wire phaseCHigh,
	output wire phaseCLow,
	output reg periodSyncPulse,
	output reg syncIrq,
	output reg [`TPTU_OUTEN_W-1:0] latchedEnable,
	output reg secondHalf
);
	// software-visible registers
	reg [`TPTU_DATA_W-1:0] halfPeriodCount_reg;
	reg [`TPTU_DEAD_W-1:0] deadTimeCount_reg;
	reg [`TPTU_DATA_W-1:0] dutyPhaseA_reg;
	reg [`TPTU_DATA_W-1:0] dutyPhaseB_reg;
	reg [`TPTU_DATA_W-1:0] dutyPhaseC_reg;
	reg doubleUpdate_reg;
	reg [`TPTU_OUTEN_W-1:0] outputEnable_reg;
	// written-once flags for start-up
	reg halfWritten_reg;
	reg dutyAWritten_reg;
	reg dutyBWritten_reg;
	reg dutyCWritten_reg;
	// shadow copies used by the timing unit
	reg [`TPTU_DATA_W-1:0] halfShadow_reg;
	reg [`TPTU_DEAD_W-1:0] deadShadow_reg;
	reg [`TPTU_DATA_W-1:0] dutyAShadow_reg;
	reg [`TPTU_DATA_W-1:0] dutyBShadow_reg;
	reg [`TPTU_DATA_W-1:0] dutyCShadow_reg;
	// period counter state
	reg [`TPTU_DATA_W-1:0] edgeDist_reg;
	reg wasRunning_reg;
	reg syncNext;
	reg loadNext;

	wire running;
	wire startPeriod;
	wire atMidpoint;
	wire atEnd;
	wire [`TPTU_DATA_W-1:0] halfLast;
	wire [`TPTU_DATA_W-1:0] newHalfLast;

	// R20: timers held until all four written
	assign running = halfWritten_reg & dutyAWritten_reg & dutyBWritten_reg & dutyCWritten_reg;
	assign startPeriod = running & ~wasRunning_reg;
	assign halfLast = halfShadow_reg - `TPTU_ONE_16;
	assign newHalfLast = halfPeriodCount_reg - `TPTU_ONE_16;
	// R01 R21: boundaries of each half
	assign atMidpoint = wasRunning_reg & ~secondHalf & (edgeDist_reg == halfLast);
	assign atEnd = wasRunning_reg & secondHalf & (edgeDist_reg == `TPTU_RST_16);

	// register writes and written-once tracking
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			halfPeriodCount_reg <= `TPTU_RST_16;
			deadTimeCount_reg <= `TPTU_RST_DEAD;
			dutyPhaseA_reg <= `TPTU_RST_16;
			dutyPhaseB_reg <= `TPTU_RST_16;
			dutyPhaseC_reg <= `TPTU_RST_16;
			doubleUpdate_reg <= 1'b0;
			outputEnable_reg <= `TPTU_RST_OUTEN;
			halfWritten_reg <= 1'b0;
			dutyAWritten_reg <= 1'b0;
			dutyBWritten_reg <= 1'b0;
			dutyCWritten_reg <= 1'b0;
		end else if (regWrite) begin
			case (regAddr)
				`TPTU_IDX_HALF: begin
					// R02: full sixteen-bit range
					halfPeriodCount_reg <= regWriteData;
					halfWritten_reg <= 1'b1;
				end
				`TPTU_IDX_DEAD: begin
					// R04: single shared dead value
					deadTimeCount_reg <= regWriteData[`TPTU_DEAD_W-1:0];
				end
				`TPTU_IDX_DUTY_A: begin
					dutyPhaseA_reg <= regWriteData;
					dutyAWritten_reg <= 1'b1;
				end
				`TPTU_IDX_DUTY_B: begin
					dutyPhaseB_reg <= regWriteData;
					dutyBWritten_reg <= 1'b1;
				end
				`TPTU_IDX_DUTY_C: begin
					dutyPhaseC_reg <= regWriteData;
					dutyCWritten_reg <= 1'b1;
				end
				`TPTU_IDX_CTRL: begin
					// R08: update mode select
					doubleUpdate_reg <= regWriteData[`TPTU_CTRL_DOUBLE_BIT];
				end
				`TPTU_IDX_OUTEN: begin
					outputEnable_reg <= regWriteData[`TPTU_OUTEN_W-1:0];
				end
				default: begin
					halfWritten_reg <= halfWritten_reg;
				end
			endcase
		end
	end

	// read data one cycle after the strobe
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			regReadData <= `TPTU_RST_16;
		end else if (regRead) begin
			case (regAddr)
				`TPTU_IDX_HALF: regReadData <= halfPeriodCount_reg;
				`TPTU_IDX_DEAD: regReadData <= {6'h00, deadTimeCount_reg};
				`TPTU_IDX_DUTY_A: regReadData <= dutyPhaseA_reg;
				`TPTU_IDX_DUTY_B: regReadData <= dutyPhaseB_reg;
				`TPTU_IDX_DUTY_C: regReadData <= dutyPhaseC_reg;
				`TPTU_IDX_CTRL: regReadData <= {13'h0000, doubleUpdate_reg, 2'b00};
				// R12: half-cycle status
				`TPTU_IDX_STATUS: regReadData <= {15'h0000, secondHalf};
				`TPTU_IDX_OUTEN: regReadData <= {7'h00, outputEnable_reg};
				default: regReadData <= `TPTU_RST_16;
			endcase
		end
	end

	// sync and load decision for this cycle
	always @* begin
		syncNext = 1'b0;
		loadNext = 1'b0;
		// R09: start of period syncs and loads
		if (startPeriod || atEnd) begin
			syncNext = 1'b1;
			loadNext = 1'b1;
		end
		// R11: extra midpoint sync in double mode
		if (atMidpoint && doubleUpdate_reg) begin
			syncNext = 1'b1;
			loadNext = 1'b1;
		end
	end

	// period counter, half flag and sync pulse
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			edgeDist_reg <= `TPTU_RST_16;
			secondHalf <= 1'b0;
			wasRunning_reg <= 1'b0;
			periodSyncPulse <= 1'b0;
			syncIrq <= 1'b0;
		end else begin
			wasRunning_reg <= running;
			periodSyncPulse <= syncNext;
			// R18: interrupt request on every sync
			syncIrq <= syncNext;
			// R21: one step per clock, reverse at midpoint
			if (startPeriod || atEnd) begin
				edgeDist_reg <= `TPTU_RST_16;
				secondHalf <= 1'b0;
			end else if (atMidpoint) begin
				// R12: status set for second half
				secondHalf <= 1'b1;
				edgeDist_reg <= loadNext ? newHalfLast : halfLast;
			end else if (wasRunning_reg && secondHalf) begin
				edgeDist_reg <= edgeDist_reg - `TPTU_ONE_16;
			end else if (wasRunning_reg) begin
				edgeDist_reg <= edgeDist_reg + `TPTU_ONE_16;
			end
		end
	end

	// shadow load on each sync
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			halfShadow_reg <= `TPTU_RST_16;
			deadShadow_reg <= `TPTU_RST_DEAD;
			dutyAShadow_reg <= `TPTU_RST_16;
			dutyBShadow_reg <= `TPTU_RST_16;
			dutyCShadow_reg <= `TPTU_RST_16;
			latchedEnable <= `TPTU_RST_OUTEN;
		end else if (loadNext) begin
			// R15: held for both halves in single mode
			halfShadow_reg <= halfPeriodCount_reg;
			deadShadow_reg <= deadTimeCount_reg;
			dutyAShadow_reg <= dutyPhaseA_reg;
			dutyBShadow_reg <= dutyPhaseB_reg;
			dutyCShadow_reg <= dutyPhaseC_reg;
			// R10: enables latched at sync
			latchedEnable <= outputEnable_reg;
		end
	end

	// R17: three complementary channels
	tptu_channel channelA (
		.mclk(mclk),
		.reset(reset),
		.running(wasRunning_reg),
		.edgeDist(edgeDist_reg),
		.halfCount(halfShadow_reg),
		.dutyCount(dutyAShadow_reg),
		.deadCount(deadShadow_reg),
		.highSide(phaseAHigh),
		.lowSide(phaseALow)
	);

	tptu_channel channelB (
		.mclk(mclk),
		.reset(reset),
		.running(wasRunning_reg),
		.edgeDist(edgeDist_reg),
		.halfCount(halfShadow_reg),
		.dutyCount(dutyBShadow_reg),
		.deadCount(deadShadow_reg),
		.highSide(phaseBHigh),
		.lowSide(phaseBLow)
	);

	tptu_channel channelC (
		.mclk(mclk),
		.reset(reset),
		.running(wasRunning_reg),
		.edgeDist(edgeDist_reg),
		.halfCount(halfShadow_reg),
		.dutyCount(dutyCShadow_reg),
		.deadCount(deadShadow_reg),
		.highSide(phaseCHigh),
		.lowSide(phaseCLow)
	);
endmodule // tptu_timing

`default_nettype wire

// File: test/tptu_gate_model.sv
`timescale 1ns/1ps
`default_nettype none
module tptu_gate_model (
	input wire logic mclk,
	input wire logic sync,
	input wire logic high,
	input wire logic low,
	output logic [16:0] highOn,
	output logic [16:0] lowOn,
	output logic shorted
);
	logic [16:0] hc = 17'h0_0000;
	logic [16:0] lc = 17'h0_0000;
	logic sh = 1'b0;
	assign shorted = sh;
	// on cycles per switch between two syncs, latched at each sync
	// high turns on
	always @(posedge mclk) begin
		hc <= sync ? 17'(high) : hc + 17'(high);
		lc <= sync ? 17'(low) : lc + 17'(low);
		if (sync) begin
			highOn <= hc;
			lowOn <= lc;
		end
		if (high && low)
			sh <= 1'b1; // both switches on: leg short
	end
endmodule // tptu_gate_model
`default_nettype wire

// File: test/tptu_timing_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tptu_timing_checker (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [2:0] regAddr,
	input wire logic [15:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regReadData,
	input wire logic phaseAHigh,
	input wire logic phaseALow,
	input wire logic phaseBHigh,
	input wire logic phaseBLow,
	input wire logic phaseCHigh,
	input wire logic phaseCLow,
	input wire logic periodSyncPulse,
	input wire logic syncIrq,
	input wire logic [8:0] latchedEnable,
	input wire logic secondHalf
);
	logic [15:0] hW, hP;
	logic mW, mP, seen;
	logic [15:0] hD;
	logic mD;
	logic [16:0] cnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// mirror of period and mode, cycles since last sync
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			hW <= 16'h0000;
			mW <= 1'b0;
			hD <= 16'h0000;
			mD <= 1'b0;
			seen <= 1'b0;
			cnt <= 17'h0_0000;
		end else begin
			// values as they stood before the edge that loads the shadows
			hD <= hW;
			mD <= mW;
			if (regWrite && regAddr == 3'h0)
				hW <= regWriteData;
			if (regWrite && regAddr == 3'h5)
				mW <= regWriteData[2];
			cnt <= periodSyncPulse ? 17'h0_0001 : cnt + 17'h0_0001;
			if (periodSyncPulse) begin
				hP <= hD;
				mP <= mD;
				seen <= 1'b1;
			end
		end
	end
	sync_spacing_a: assert property (
		periodSyncPulse && seen && mD == mP |-> cnt == (mP ? {1'b0, hP} : {hP, 1'b0}))
		else $error("sync spacing wrong");
	irq_pair_a: assert property (syncIrq == periodSyncPulse)
		else $error("irq differs from sync");
	sync_width_a: assert property (periodSyncPulse |=> !periodSyncPulse)
		else $error("sync longer than one cycle");
	half_clear_a: assert property ($fell(secondHalf) |-> periodSyncPulse)
		else $error("status cleared off sync");
	half_set_a: assert property (
		$rose(secondHalf) && mD == mP |-> cnt == {1'b0, hP} && periodSyncPulse == mP)
		else $error("midpoint wrong");
	no_overlap_a: assert property (
		!(phaseAHigh && phaseALow) && !(phaseBHigh && phaseBLow) && !(phaseCHigh && phaseCLow))
		else $error("pair both on");
	enable_latch_a: assert property ($changed(latchedEnable) |-> periodSyncPulse)
		else $error("enable latched off sync");
	read_hold_a: assert property ($changed(regReadData) |-> $past(regRead))
		else $error("read data moved without read");
endmodule // tptu_timing_checker
bind tptu_timing tptu_timing_checker chk (.mclk, .reset, .regAddr, .regWriteData, .regWrite,
	.regRead, .regReadData, .phaseAHigh, .phaseALow, .phaseBHigh, .phaseBLow, .phaseCHigh,
	.phaseCLow, .periodSyncPulse, .syncIrq, .latchedEnable, .secondHalf);
`default_nettype wire

// File: test/tptu_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [15:0] regWriteData = 16'h0000;
	logic [15:0] regReadData;
	logic [2:0] hi, lo, shorted;
	logic [16:0] hOn [3];
	logic [16:0] lOn [3];
	logic periodSyncPulse, syncIrq, secondHalf, s;
	logic [8:0] latchedEnable;
	int fail_count = 0;
	int check_count = 0;
	int syncs = 0;
	int n;
	always #20 mclk = ~mclk;
	tptu_timing dut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .phaseAHigh(hi[0]),
		.phaseALow(lo[0]), .phaseBHigh(hi[1]), .phaseBLow(lo[1]), .phaseCHigh(hi[2]),
		.phaseCLow(lo[2]), .periodSyncPulse(periodSyncPulse), .syncIrq(syncIrq),
		.latchedEnable(latchedEnable), .secondHalf(secondHalf));
	// one gate driver per phase
	for (genvar i = 0; i < 3; i++) begin : gate
		tptu_gate_model drv (.mclk(mclk), .sync(periodSyncPulse), .high(hi[i]), .low(lo[i]),
			.highOn(hOn[i]), .lowOn(lOn[i]), .shorted(shorted[i]));
	end
	always @(posedge mclk) begin
		if (periodSyncPulse)
			syncs++;
	end
	task check(input logic [16:0] seen, input logic [16:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wr(input logic [2:0] a, input logic [15:0] d);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [2:0] a, input logic [15:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1 check({1'b0, regReadData}, {1'b0, e});
		@(posedge mclk);
	endtask
	// edges until the next sync, bounded
	task waitSync;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (periodSyncPulse !== 1'b1 && n < 1000);
	endtask
	function automatic logic [16:0] onT(input int x, input int h);
		return 17'(2 * ((x < 0) ? 0 : (x > h) ? h : x));
	endfunction
	// load a setting, skip a period, then measure one whole period
	task automatic runPeriod(input int h, input int dt, input int d [3]);
		wr(3'h0, 16'(h));
		wr(3'h1, 16'(dt));
		for (int i = 0; i < 3; i++)
			wr(3'(i + 2), 16'(d[i]));
		repeat (3) waitSync;
		check(17'(n), 17'(2 * h));
		@(posedge mclk);
		#1;
		for (int i = 0; i < 3; i++) begin
			check(hOn[i], onT(d[i] - dt, h));
			check(lOn[i], onT(h - d[i] - dt, h));
		end
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 8; i++)
			rd(3'(i), 16'h0000);
		wr(3'h0, 16'hFFFF);
		rd(3'h0, 16'hFFFF);
		wr(3'h1, 16'hFFFF);
		rd(3'h1, 16'h03FF);
		wr(3'h5, 16'hFFFF);
		rd(3'h5, 16'h0004);
		wr(3'h6, 16'hFFFF);
		rd(3'h6, 16'h0000);
		wr(3'h7, 16'hFFFF);
		rd(3'h7, 16'h01FF);
		wr(3'h5, 16'h0000);
		wr(3'h1, 16'h0000);
		wr(3'h0, 16'h0008);
		wr(3'h2, 16'h0002);
		wr(3'h3, 16'h0002);
		repeat (40) @(posedge mclk);
		check(17'(syncs), 17'h0_0000);
		runPeriod(8, 0, '{4, 0, 8});
		runPeriod(2, 0, '{0, 1, 2}); // smallest legal period
		runPeriod(6, 2, '{1, 3, 6});
		runPeriod(8, 1, '{4, 2, 6});
		wr(3'h7, 16'h01A5);
		wr(3'h5, 16'h0004);
		repeat (3) waitSync;
		check(17'(latchedEnable), 17'h0_01A5);
		repeat (2) begin
			s = secondHalf;
			waitSync;
			check(17'(n), 17'h0_0008);
			check({16'h0000, secondHalf ^ s}, 17'h0_0001);
		end
		check(17'(shorted), 17'h0_0000);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		syncs = 0;
		repeat (40) @(posedge mclk);
		check(17'(syncs), 17'h0_0000);
		rd(3'h0, 16'h0000);
		conclude;
	end
	// watchdog well beyond the expected run
	initial begin
		#400000;
		fail_count++;
		conclude;
	end
endmodule // testbench
`default_nettype wire
